/* File: src/gcm_ctrl.sv */
// General port control and interface clocking select behind the serial port
//
// How it works
// RULE1: Reg 0 bit 7 low: separate data pins; high: data-in pin is two-way.
// RULE2: Reg 0 bit 6 low shifts MSB first, high LSB first, on both sides.
// RULE3: A one written to reg 0 bit 5 restores defaults and relocks the PLL.
// RULE4: The soft reset bit is one-shot: never stored, it always reads zero.
// RULE5: Reg 1 bits 7:5 reset to 000, standard clocking (modes 1, 4 and 7).
// RULE6: Select code 001 gives alternative full-duplex timing (mode 2).
// RULE7: Code 011 selects alternative half-duplex parallel timing (mode 5).
// RULE8: Code 101 selects alternative half-duplex interleaved timing (mode 8).
// RULE9: Code 111 selects clone mode clocking (mode 10).
// RULE10: Host avoids codes 010, 100 and 110; they decode as standard.
`timescale 1ns/1ps
`default_nettype none
`include "gcm_defs.svh"

module gcm_ctrl
  import gcm_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          spi_sclk,
  input  wire logic          spi_cs_n,
  input  wire logic          sdio_in,
  output var  logic          sdio_out,
  output var  logic          sdio_oe,
  output var  logic          serial_data_out_pin,
  output var  logic          serial_data_out_oe,
  output var  logic          shared_data_pin_select,
  output var  logic          lsb_first,
  output var  logic          config_reset_pulse,
  output var  logic          pll_relock_pulse,
  output var  logic [2:0]    clk_select_code,
  output var  gcm_clk_mode_t iface_clk_mode
);

  logic [2:0]    sclk_sync_reg;
  logic [2:0]    cs_sync_reg;
  logic [1:0]    din_sync_reg;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          cs_active;
  logic [4:0]    bit_cnt_reg;
  logic [7:0]    shift_reg;
  logic [7:0]    shift_next;
  logic [7:0]    instr_reg;
  logic [7:0]    tx_reg;
  logic          out_bit_reg;
  logic          read_phase_reg;
  logic [7:0]    general_reg;
  logic [7:0]    clksel_reg;
  logic [7:0]    read_data;
  logic          wr_done;
  logic [6:0]    wr_addr;
  gcm_clk_mode_t mode_next;

  // Two-stage synchronisers; the third stage of sclk is for edges, the third stage of cs is unused
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      din_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
      din_sync_reg  <= {din_sync_reg[0], sdio_in};
    end
  end

  // Edges are taken only from settled stages, never from the first flop
  assign cs_active = ~cs_sync_reg[1];
  assign sclk_rise = cs_active & sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = cs_active & ~sclk_sync_reg[1] & sclk_sync_reg[2];

  // Incoming bit enters at the end that matches the chosen bit order
  always_comb begin
    if (lsb_first) begin
      shift_next = {din_sync_reg[1], shift_reg[7:1]}; // see RULE2
    end else begin
      shift_next = {shift_reg[6:0], din_sync_reg[1]}; // see RULE2
    end
  end

  // Bit counter and receive shifter; a dropped select aborts the frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 8'h00;
      instr_reg   <= 8'h00;
    end else if (!cs_active) begin
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise && bit_cnt_reg != `GCM_FRAME_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg   <= shift_next;
      if (bit_cnt_reg == `GCM_INSTR_BITS - 5'h01) begin
        instr_reg <= shift_next;
      end
    end
  end

  // A write completes on the last rising edge of a frame with read flag low
  assign wr_done = sclk_rise & ~instr_reg[`GCM_READ_FLAG]
                 & (bit_cnt_reg == `GCM_FRAME_BITS - 5'h01);
  assign wr_addr = instr_reg[6:0];

  // Read-back mux; the soft reset position always reads zero
  always_comb begin
    read_data = 8'h00;
    if (instr_reg[6:0] == `GCM_ADDR_GENERAL_PORT_CONTROL) begin
      read_data = general_reg;
    end else if (instr_reg[6:0] == `GCM_ADDR_INTERFACE_CLOCKING_SELECT) begin
      read_data = clksel_reg;
    end
  end

  // Register writes; soft reset overrides everything else in the same write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_reg <= `GCM_RST_GENERAL_PORT_CONTROL;
      clksel_reg  <= `GCM_RST_INTERFACE_CLOCKING_SELECT;
    end else if (wr_done && wr_addr == `GCM_ADDR_GENERAL_PORT_CONTROL) begin
      if (shift_next[`GCM_BIT_SOFT_RESET]) begin
        general_reg <= `GCM_RST_GENERAL_PORT_CONTROL; // see RULE3
        clksel_reg  <= `GCM_RST_INTERFACE_CLOCKING_SELECT; // see RULE3
      end else begin
        // Bit 5 is not kept, so it never reads back set
        general_reg <= {shift_next[7:6], 6'h00}; // see RULE1 see RULE4
      end
    end else if (wr_done
                 && wr_addr == `GCM_ADDR_INTERFACE_CLOCKING_SELECT) begin
      clksel_reg <= shift_next; // see RULE5
    end
  end

  // One-cycle pulses: other banks reset and the PLL reacquires lock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reset_pulse <= 1'b0;
      pll_relock_pulse   <= 1'b0;
    end else begin
      config_reset_pulse <= wr_done
        & (wr_addr == `GCM_ADDR_GENERAL_PORT_CONTROL)
        & shift_next[`GCM_BIT_SOFT_RESET]; // see RULE3
      pll_relock_pulse   <= wr_done
        & (wr_addr == `GCM_ADDR_GENERAL_PORT_CONTROL)
        & shift_next[`GCM_BIT_SOFT_RESET]; // see RULE3
    end
  end

  // Transmit side: load after the instruction, present bits on falling edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg         <= 8'h00;
      out_bit_reg    <= 1'b0;
      read_phase_reg <= 1'b0;
    end else if (!cs_active) begin
      read_phase_reg <= 1'b0;
    end else if (sclk_rise && bit_cnt_reg == `GCM_INSTR_BITS - 5'h01) begin
      read_phase_reg <= shift_next[`GCM_READ_FLAG];
      tx_reg         <= 8'h00;
    end else if (sclk_rise && bit_cnt_reg == `GCM_INSTR_BITS) begin
      tx_reg <= tx_reg;
    end else if (sclk_fall && bit_cnt_reg == `GCM_INSTR_BITS
                 && read_phase_reg && tx_reg == 8'h00) begin
      // First data bit: take the register now so a late write is seen
      if (lsb_first) begin
        out_bit_reg <= read_data[0]; // see RULE2
        tx_reg      <= {1'b0, read_data[7:1]};
      end else begin
        out_bit_reg <= read_data[7]; // see RULE2
        tx_reg      <= {read_data[6:0], 1'b0};
      end
    end else if (sclk_fall && bit_cnt_reg > `GCM_INSTR_BITS
                 && bit_cnt_reg < `GCM_FRAME_BITS) begin
      if (lsb_first) begin
        out_bit_reg <= tx_reg[0]; // see RULE2
        tx_reg      <= {1'b0, tx_reg[7:1]};
      end else begin
        out_bit_reg <= tx_reg[7]; // see RULE2
        tx_reg      <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Pin steering: read data goes to the shared pin or the dedicated one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdio_out            <= 1'b0;
      sdio_oe             <= 1'b0;
      serial_data_out_pin <= 1'b0;
      serial_data_out_oe  <= 1'b0;
    end else begin
      sdio_out            <= out_bit_reg;
      serial_data_out_pin <= out_bit_reg;
      sdio_oe             <= read_phase_reg & cs_active
                           & shared_data_pin_select; // see RULE1
      serial_data_out_oe  <= read_phase_reg & cs_active
                           & ~shared_data_pin_select; // see RULE1
    end
  end

  // Clocking decode; unused codes fall back to standard clocking
  always_comb begin
    unique case (clksel_reg[`GCM_CLKSEL_MSB:`GCM_CLKSEL_LSB])
      `GCM_CODE_ALT_FULL: mode_next = GCM_CLK_ALT_FULL; // see RULE6
      `GCM_CODE_ALT_PAR:  mode_next = GCM_CLK_ALT_PAR;  // see RULE7
      `GCM_CODE_ALT_ILV:  mode_next = GCM_CLK_ALT_ILV;  // see RULE8
      `GCM_CODE_CLONE:    mode_next = GCM_CLK_CLONE;    // see RULE9
      default:            mode_next = GCM_CLK_STANDARD; // see RULE5 see RULE10
    endcase
  end

  // Configuration outputs, registered one cycle after the bank
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_data_pin_select <= 1'b0;
      lsb_first              <= 1'b0;
      clk_select_code        <= 3'h0;
      iface_clk_mode         <= GCM_CLK_STANDARD;
    end else begin
      shared_data_pin_select <= general_reg[`GCM_BIT_SHARED_DATA_PIN];
      lsb_first              <= general_reg[`GCM_BIT_LSB_FIRST];
      clk_select_code <= clksel_reg[`GCM_CLKSEL_MSB:`GCM_CLKSEL_LSB];
      iface_clk_mode         <= mode_next;
    end
  end

endmodule : gcm_ctrl
`default_nettype wire

/* File: include/gcm_defs.svh */
// Register map, field positions, reset values and codes for the control bank
`ifndef GCM_DEFS_SVH
`define GCM_DEFS_SVH

// Register addresses on the serial configuration port
`define GCM_ADDR_GENERAL_PORT_CONTROL      7'h00
`define GCM_ADDR_INTERFACE_CLOCKING_SELECT 7'h01

// General port control fields
`define GCM_BIT_SHARED_DATA_PIN 7
`define GCM_BIT_LSB_FIRST       6
`define GCM_BIT_SOFT_RESET      5

// Interface clocking select field
`define GCM_CLKSEL_MSB 7
`define GCM_CLKSEL_LSB 5

// Reset values
`define GCM_RST_GENERAL_PORT_CONTROL      8'h00
`define GCM_RST_INTERFACE_CLOCKING_SELECT 8'h00

// Clock select codes
`define GCM_CODE_STANDARD  3'h0
`define GCM_CODE_ALT_FULL  3'h1
`define GCM_CODE_ALT_PAR   3'h3
`define GCM_CODE_ALT_ILV   3'h5
`define GCM_CODE_CLONE     3'h7

// Serial frame layout: one instruction byte then one data byte
`define GCM_FRAME_BITS   5'h10
`define GCM_INSTR_BITS   5'h08
`define GCM_READ_FLAG    7

`endif

/* File: include/gcm_pkg.sv */
// Types for the general and clock mode control bank
package gcm_pkg;

  // Decoded interface clocking variant
  typedef enum logic [2:0] {
    GCM_CLK_STANDARD  = 3'b000,
    GCM_CLK_ALT_FULL  = 3'b001,
    GCM_CLK_ALT_PAR   = 3'b011,
    GCM_CLK_ALT_ILV   = 3'b101,
    GCM_CLK_CLONE     = 3'b111
  } gcm_clk_mode_t;

endpackage : gcm_pkg

/* File: tb/gcm_ctrl_asserts.sv */
// Port-level checks of the control bank
`timescale 1ns/1ps
`default_nettype none
module gcm_chk
  import gcm_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic          sdio_oe,
  input wire logic          serial_data_out_oe,
  input wire logic          shared_data_pin_select,
  input wire logic          lsb_first,
  input wire logic          config_reset_pulse,
  input wire logic          pll_relock_pulse,
  input wire logic [2:0]    clk_select_code,
  input var  gcm_clk_mode_t iface_clk_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Decoded mode follows the stored code in the same cycle
  chk_mode_std: assert property (clk_select_code == 3'h0 |->
    iface_clk_mode == GCM_CLK_STANDARD) else $error("standard decode");
  chk_mode_full: assert property (clk_select_code == 3'h1 |->
    iface_clk_mode == GCM_CLK_ALT_FULL) else $error("alt full decode");
  chk_mode_par: assert property (clk_select_code == 3'h3 |->
    iface_clk_mode == GCM_CLK_ALT_PAR) else $error("alt par decode");
  chk_mode_ilv: assert property (clk_select_code == 3'h5 |->
    iface_clk_mode == GCM_CLK_ALT_ILV) else $error("alt ilv decode");
  chk_mode_clone: assert property (clk_select_code == 3'h7 |->
    iface_clk_mode == GCM_CLK_CLONE) else $error("clone decode");
  chk_unused_std: assert property (!clk_select_code[0] &&
    clk_select_code != 3'h0 |-> iface_clk_mode == GCM_CLK_STANDARD)
    else $error("unused code decode");
  // Soft reset is a single pulse, paired with relock, then defaults
  chk_pulse_once: assert property (config_reset_pulse |=>
    !config_reset_pulse) else $error("reset pulse too long");
  chk_reset_dflt: assert property (config_reset_pulse |->
    pll_relock_pulse ##[0:2] (clk_select_code == 3'h0 && !lsb_first))
    else $error("soft reset defaults");
  chk_pin_route: assert property (sdio_oe |->
    shared_data_pin_select) else $error("shared pin driven");
  // Only one data pin is ever driven, and the dedicated one only when split
  chk_pin_split: assert property (serial_data_out_oe |->
    !shared_data_pin_select && !sdio_oe) else $error("dedicated pin driven");
  cover property (config_reset_pulse);
  cover property (sdio_oe);
  cover property (iface_clk_mode == GCM_CLK_CLONE);
endmodule : gcm_chk
bind gcm_ctrl gcm_chk chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .sdio_oe(sdio_oe), .serial_data_out_oe(serial_data_out_oe),
  .shared_data_pin_select(shared_data_pin_select),
  .lsb_first(lsb_first), .config_reset_pulse(config_reset_pulse),
  .pll_relock_pulse(pll_relock_pulse), .clk_select_code(clk_select_code),
  .iface_clk_mode(iface_clk_mode));
`default_nettype wire

/* File: tb/gcm_host.sv */
// Host model driving the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module gcm_host (
  input  wire logic sys_clk,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_data_out_pin,
  input  wire logic serial_data_out_oe,
  output var  logic spi_sclk,
  output var  logic spi_cs_n,
  output wire logic sdio_in
);
  logic tx_bit;
  // Shared pin level; host toggles it when released to expose no driver
  assign sdio_in = sdio_oe ? sdio_out : tx_bit;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    tx_bit = 1'b0;
  end
  // One frame; 8-cycle half periods leave margin over the 5-cycle floor
  task automatic xfer(input logic rd, input logic [6:0] a,
    input logic [7:0] d, input logic lsb, input logic sh,
    output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge sys_clk) #1 spi_cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      tx_bit = (rd && i > 7) ? i[0] :
        lsb ? f[(i < 8 ? 8 : 0) + i % 8] : f[15 - i];
      repeat (8) @(posedge sys_clk);
      if (rd && i > 7)
        q[lsb ? i - 8 : 15 - i] = sh ? sdio_in :
          serial_data_out_oe ? serial_data_out_pin : ~serial_data_out_pin;
      #1 spi_sclk = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 spi_sclk = 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    #1 spi_cs_n = 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : xfer
endmodule : gcm_host
`default_nettype wire

/* File: tb/gcm_ctrl_tb.sv */
// Self-checking bench for the control bank
`timescale 1ns/1ps
`default_nettype none
module gcm_ctrl_tb;
  import gcm_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, lsb_r = 1'b0, sh_r = 1'b0;
  wire logic sclk, cs_n, sdi, dout, dout_oe, pin, pin_oe, shr, lsb, crp, pll;
  wire logic [2:0] code;
  gcm_clk_mode_t mode;
  int err_total = 0, tests_run = 0, cyc = 0, pulses = 0, relocks = 0;
  logic [7:0] q;
  always #5 sys_clk = ~sys_clk;
  gcm_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .sdio_in(sdi), .sdio_out(dout), .sdio_oe(dout_oe),
    .serial_data_out_pin(pin), .serial_data_out_oe(pin_oe),
    .shared_data_pin_select(shr), .lsb_first(lsb),
    .config_reset_pulse(crp), .pll_relock_pulse(pll),
    .clk_select_code(code), .iface_clk_mode(mode));
  gcm_host host (.sys_clk(sys_clk), .sdio_out(dout), .sdio_oe(dout_oe),
    .serial_data_out_pin(pin), .serial_data_out_oe(pin_oe),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .sdio_in(sdi));
  // Pulse counts and hang guard; a run needs about 7600 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (crp === 1'b1) pulses++;
    if (pll === 1'b1) relocks++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b0, a, d, lsb_r, sh_r, x);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.xfer(1'b1, a, 8'h00, lsb_r, sh_r, d);
  endtask : rd
  // Main sequence; unused codes sit last in the table
  initial begin
    logic [2:0] cd [8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7, 3'h2, 3'h4, 3'h6};
    logic [2:0] md [8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7, 3'h0, 3'h0, 3'h0};
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(7'h00, q);
    chk("reg0 reset", q, 8'h00);
    rd(7'h01, q);
    chk("reg1 reset", q, 8'h00);
    wr(7'h05, 8'h55);
    rd(7'h05, q);
    chk("unmapped", q, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(7'h01, {cd[i], 5'h0a});
      chk("code", {5'h00, code}, {5'h00, cd[i]});
      chk("mode", 8'(mode), 8'(md[i]));
      rd(7'h01, q);
      chk("reg1", q, {cd[i], 5'h0a});
    end
    $display("test clock modes done");
    wr(7'h00, 8'h40);
    chk("lsb flag", {7'h00, lsb}, 8'h01);
    lsb_r = 1'b1;
    wr(7'h01, 8'h6c);
    chk("lsb code", {5'h00, code}, 8'h03);
    wr(7'h00, 8'hc0);
    sh_r = 1'b1;
    chk("shared flag", {7'h00, shr}, 8'h01);
    rd(7'h01, q);
    chk("shared read", q, 8'h6c);
    rd(7'h00, q);
    chk("reg0 set", q, 8'hc0);
    $display("test pin and order done");
    wr(7'h00, 8'he0);
    lsb_r = 1'b0;
    sh_r = 1'b0;
    chk("pulses", pulses[7:0], 8'h01);
    chk("relocks", relocks[7:0], 8'h01);
    chk("flags after", {6'h00, shr, lsb}, 8'h00);
    rd(7'h00, q);
    chk("reg0 after", q, 8'h00);
    rd(7'h01, q);
    chk("reg1 after", q, 8'h00);
    $display("test soft reset done");
    close_out();
  end
endmodule : gcm_ctrl_tb
`default_nettype wire
